// ===== shared/asa_regs.svh
// register offsets, field positions, fixed tags and launch keys
`ifndef ASA_REGS_SVH
`define ASA_REGS_SVH
`define ASA_OFS_CTRL 8'h1e
`define ASA_OFS_ANGLE 8'h20
`define ASA_OFS_STATUS 8'h22
`define ASA_OFS_ERR 8'h24
`define ASA_OFS_WARN 8'h26
`define ASA_CTRL_CLR_STATUS 10
`define ASA_CTRL_CLR_WARN 9
`define ASA_CTRL_CLE 8
`define ASA_ERR_WARN_SUM 11
`define ASA_ERR_PIN_LOW 3
`define ASA_ERR_REG_LOW 2
`define ASA_ERR_RESET 12'h001
`define ASA_WARN_RESET 12'h000
`define ASA_WARN_USED 12'hdff
`define ASA_TAG_STATUS 4'h8
`define ASA_TAG_ERR 4'ha
`define ASA_TAG_WARN 4'hb
`define ASA_KEY_SELFTEST 8'hb9
`define ASA_KEY_TURNS 8'h46
`define ASA_KEY_HARD 8'h5a
`define ASA_SEL_FRONTEND 4'h9
`define ASA_SEL_LOGIC 4'ha
`define ASA_SEL_BOTH 4'hb
`define ASA_SEL_TURNS 4'h4
`define ASA_SEL_HARD 4'h7
`define ASA_SEL_MARGIN_LO 4'h1
`define ASA_SEL_MARGIN_HI 4'h2
`endif

// ===== shared/asa_pkg.sv
// types shared by the status and control register group
package asa_pkg;
   typedef struct packed {
      logic wr;
      logic [7:0] addr;
      logic [15:0] wdata;
   } asa_req_type;

   typedef struct packed {
      logic [11:0] angle;
      logic loop_locked;
      logic startup_done;
      logic rotation_direction;
      logic logic_selftest_running;
      logic frontend_selftest_running;
      logic boot_in_progress;
      logic boot_done_evt;
      logic action_done_evt;
      logic [1:0] die_number;
   } asa_sense_type;

   typedef struct packed {
      logic frontend_selftest;
      logic logic_selftest;
      logic turns_reset;
      logic hard_reset;
   } asa_launch_type;
endpackage : asa_pkg

// ===== verilog/asa_sync.sv
// two-flop synchroniser for levels and toggles
`timescale 1ns/1ns
module asa_sync #(
   parameter int W = 1
) (
   input wire logic clock,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_reg;

   // first stage is read only by the second
   always_ff @(posedge clock) begin
      meta_reg <= d;
      q <= meta_reg;
   end
endmodule : asa_sync

// ===== verilog/asa_link_port.sv
// link-clock side of the register access handshake
`timescale 1ns/1ns
module asa_link_port (
   input wire logic link_clock,
   input wire logic srst,
   input wire logic link_req,
   input wire asa_pkg::asa_req_type link_req_data,
   input wire logic ack_tgl,
   input wire logic [15:0] core_rdata,
   output logic link_busy,
   output logic link_done,
   output logic [15:0] link_rdata,
   output logic req_tgl_reg,
   output asa_pkg::asa_req_type req_hold_reg
);
   logic srst_link;
   logic ack_sync;
   logic pending_reg;
   logic req_take;

   asa_sync #(.W(1)) u_rst_sync (.clock(link_clock), .d(srst), .q(srst_link));
   asa_sync #(.W(1)) u_ack_sync (.clock(link_clock), .d(ack_tgl), .q(ack_sync));

   // busy until the core returns the toggle; held words stay still meanwhile
   assign link_busy = req_tgl_reg ^ ack_sync;
   // no capture while done stands: the host still holds its old request then
   assign req_take = link_req && !link_busy && !pending_reg && !link_done;

   always_ff @(posedge link_clock) begin
      if (srst_link) begin
         req_tgl_reg <= 1'b0;
         req_hold_reg <= '0;
      end else if (req_take) begin
         req_hold_reg <= link_req_data;
         req_tgl_reg <= ~req_tgl_reg;
      end
   end

   always_ff @(posedge link_clock) begin
      if (srst_link) begin
         pending_reg <= 1'b0;
         link_done <= 1'b0;
         link_rdata <= 16'h0000;
      end else begin
         link_done <= 1'b0;
         if (req_take) begin
            pending_reg <= 1'b1;
         end else if (pending_reg && !link_busy) begin
            // core answer word is stable once the ack toggle has landed
            pending_reg <= 1'b0;
            link_done <= 1'b1;
            link_rdata <= core_rdata;
         end
      end
   end
endmodule : asa_link_port

// ===== verilog/asa_status_ctrl_regs.sv
// angle, status, error, warning and control registers of the angle sensor
//
// Notes on behaviour
// RL1: clear-warnings bit clears only warning bits already read; reads back zero.
// RL2: clear-errors bit clears only error bits already read; reads back zero.
// RL3: host sets action selection first, then writes initiate key; key reads zero.
// RL4: key b9 starts self-tests, 46 turns reset, 5a hard reset; others nothing.
// RL5: angle word is zero, fault flag, supply flag, parity, 12-bit angle.
// RL6: fault flag is one whenever any unmasked error or warning bit is set.
// RL7: supply flag is live OR of both low detectors, each maskable.
// RL8: parity makes the whole angle word hold an odd count of ones.
// RL9: angle field carries the tracking loop angle, 360/4096 degrees per step.
// RL10: status tag bits read 1000, error tag bits read 1010.
// RL11: status bit 7 shows rotation direction, one for decreasing angles.
// RL12: action-done drops at launch, rises on completion, clear-status clears it.
// RL13: boot-done sets after load and startup tests; clear-status clears it.
// RL14: status bits 3 and 2 show logic and front-end self-tests running.
// RL15: status bit 1 shows boot in progress.
// RL16: status bit 0 is one only when loop locked and startup complete.
// RL17: error flags latch until read and then cleared by the host.
// RL18: error bit 11 sets on any unmasked warning unless its mask is set.
// RL19: error bit 10 sets on logic or front-end self-test failure.
// RL20: error bit 9 sets when averaging is too slow for the rotation speed.
// RL21: error bit 7 sets when the tracking loop loses lock.
// RL22: error bit 6 on zero-crossing timeout, bit 8 on quadrature fault.
// RL23: clear-status bit clears both action-done and boot-done.
// RL24: selections 1001, 1010, 1011 pick front-end, logic, or both self-tests.
// RL25: an error or warning clear never drops a bit the host has not yet read.
`timescale 1ns/1ns
`include "asa_regs.svh"
module asa_status_ctrl_regs (
   input wire logic clock,
   input wire logic srst,
   input wire logic link_clock,
   input wire logic link_req,
   input wire asa_pkg::asa_req_type link_req_data,
   output logic link_busy,
   output logic link_done,
   output logic [15:0] link_rdata,
   input wire asa_pkg::asa_sense_type sense,
   input wire logic [10:0] fault_evt,
   input wire logic supply_pin_low_detect,
   input wire logic regulator_low_detect,
   input wire logic [11:0] warn_evt,
   input wire logic [11:0] err_mask,
   input wire logic [11:0] warn_mask,
   output asa_pkg::asa_launch_type launch_reg
);
   // ****************************************************************
   // link crossing
   // ****************************************************************
   logic req_tgl;
   logic req_tgl_sync;
   logic req_last_reg;
   logic ack_tgl_reg;
   logic acc_go;
   logic [15:0] rdata_reg;
   asa_pkg::asa_req_type acc;

   asa_link_port u_link (
      .link_clock(link_clock),
      .srst(srst),
      .link_req(link_req),
      .link_req_data(link_req_data),
      .ack_tgl(ack_tgl_reg),
      .core_rdata(rdata_reg),
      .link_busy(link_busy),
      .link_done(link_done),
      .link_rdata(link_rdata),
      .req_tgl_reg(req_tgl),
      .req_hold_reg(acc)
   );

   asa_sync #(.W(1)) u_req_sync (.clock(clock), .d(req_tgl), .q(req_tgl_sync));

   // held request word is quiet by the time the synced toggle differs
   assign acc_go = req_tgl_sync ^ req_last_reg;

   always_ff @(posedge clock) begin
      if (srst) begin
         req_last_reg <= 1'b0;
         ack_tgl_reg <= 1'b0;
      end else begin
         req_last_reg <= req_tgl_sync;
         ack_tgl_reg <= ack_tgl_reg ^ acc_go;
      end
   end

   // ****************************************************************
   // access decode
   // ****************************************************************
   logic wr_ctrl;
   logic rd_angle;
   logic rd_status;
   logic rd_err;
   logic rd_warn;
   logic rd_ctrl;
   logic clr_status_hit;
   logic clr_warn_hit;
   logic cle_hit;
   logic [7:0] key;

   assign wr_ctrl = acc_go && acc.wr && (acc.addr == `ASA_OFS_CTRL);
   assign rd_angle = acc_go && !acc.wr && (acc.addr == `ASA_OFS_ANGLE);
   assign rd_status = acc_go && !acc.wr && (acc.addr == `ASA_OFS_STATUS);
   assign rd_err = acc_go && !acc.wr && (acc.addr == `ASA_OFS_ERR);
   assign rd_warn = acc_go && !acc.wr && (acc.addr == `ASA_OFS_WARN);
   assign rd_ctrl = acc_go && !acc.wr && (acc.addr == `ASA_OFS_CTRL);
   assign clr_status_hit = wr_ctrl && acc.wdata[`ASA_CTRL_CLR_STATUS];
   assign clr_warn_hit = wr_ctrl && acc.wdata[`ASA_CTRL_CLR_WARN];
   assign cle_hit = wr_ctrl && acc.wdata[`ASA_CTRL_CLE];
   assign key = acc.wdata[7:0];

   // ****************************************************************
   // special actions
   // ****************************************************************
   logic [3:0] special_reg;
   logic st_sel;
   logic st_go;
   logic turns_go;
   logic hard_go;
   logic any_go;

   assign st_sel = (special_reg == `ASA_SEL_FRONTEND) || (special_reg == `ASA_SEL_LOGIC)
      || (special_reg == `ASA_SEL_BOTH); // RL24
   // decode uses the selection stored before this write
   assign st_go = wr_ctrl && (key == `ASA_KEY_SELFTEST) && st_sel; // RL3 RL4
   assign turns_go = wr_ctrl && (key == `ASA_KEY_TURNS)
      && (special_reg == `ASA_SEL_TURNS); // RL4
   assign hard_go = wr_ctrl && (key == `ASA_KEY_HARD)
      && (special_reg == `ASA_SEL_HARD); // RL4
   assign any_go = st_go || turns_go || hard_go;

   always_ff @(posedge clock) begin
      if (srst) begin
         special_reg <= 4'h0;
      end else if (wr_ctrl) begin
         special_reg <= acc.wdata[15:12]; // RL3
      end else if (sense.action_done_evt && (special_reg != `ASA_SEL_MARGIN_LO)
         && (special_reg != `ASA_SEL_MARGIN_HI)) begin
         // margin selections persist; everything else returns to no action
         special_reg <= 4'h0;
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         launch_reg <= '0;
      end else begin
         launch_reg.frontend_selftest <= st_go && special_reg[0]; // RL24
         launch_reg.logic_selftest <= st_go && special_reg[1]; // RL24
         launch_reg.turns_reset <= turns_go;
         launch_reg.hard_reset <= hard_go;
      end
   end

   // ****************************************************************
   // status bits
   // ****************************************************************
   logic action_done_reg;
   logic boot_done_reg;
   logic angle_valid;

   always_ff @(posedge clock) begin
      if (srst) begin
         action_done_reg <= 1'b0;
      end else if (any_go) begin
         action_done_reg <= 1'b0; // RL12
      end else if (sense.action_done_evt) begin
         action_done_reg <= 1'b1; // RL12
      end else if (clr_status_hit) begin
         action_done_reg <= 1'b0; // RL23
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         boot_done_reg <= 1'b0;
      end else if (sense.boot_done_evt) begin
         boot_done_reg <= 1'b1; // RL13
      end else if (clr_status_hit) begin
         boot_done_reg <= 1'b0; // RL23
      end
   end

   assign angle_valid = sense.loop_locked && sense.startup_done; // RL16

   // ****************************************************************
   // latched error and warning flags
   // ****************************************************************
   logic [11:0] err_reg;
   logic [11:0] err_seen_reg;
   logic [11:0] err_set;
   logic [11:0] err_unread;
   logic [11:0] warn_reg;
   logic [11:0] warn_seen_reg;
   logic [11:0] warn_set;
   logic warning_summary;

   assign warning_summary = (|(warn_reg & ~warn_mask)) && !err_mask[`ASA_ERR_WARN_SUM]; // RL18
   // fault_evt carries self-test fail, averaging, quadrature, lock loss, zero-crossing
   assign err_set = {warning_summary, fault_evt[10:4], // RL19 RL20 RL21 RL22
      fault_evt[3] || supply_pin_low_detect, fault_evt[2] || regulator_low_detect,
      fault_evt[1:0]};
   assign warn_set = warn_evt & `ASA_WARN_USED;
   assign err_unread = err_reg & ~err_seen_reg;

   // a set arriving with the clear survives; unread bits are never dropped
   always_ff @(posedge clock) begin
      if (srst) begin
         err_reg <= `ASA_ERR_RESET;
         err_seen_reg <= 12'h000;
      end else if (cle_hit) begin
         err_reg <= err_unread | err_set; // RL2 RL25
         err_seen_reg <= 12'h000;
      end else begin
         err_reg <= err_reg | err_set; // RL17
         // a bit set again after its read counts as unread once more
         err_seen_reg <= rd_err ? err_reg : (err_seen_reg & ~err_set); // RL25
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         warn_reg <= `ASA_WARN_RESET;
         warn_seen_reg <= 12'h000;
      end else if (clr_warn_hit) begin
         warn_reg <= (warn_reg & ~warn_seen_reg) | warn_set; // RL1 RL25
         warn_seen_reg <= 12'h000;
      end else begin
         warn_reg <= warn_reg | warn_set;
         warn_seen_reg <= rd_warn ? warn_reg : (warn_seen_reg & ~warn_set); // RL25
      end
   end

   // ****************************************************************
   // read words
   // ****************************************************************
   logic any_fault_flag;
   logic low_supply_flag;
   logic [15:0] angle_word;
   logic [15:0] status_word;
   logic [15:0] rd_word;

   assign any_fault_flag = |(err_reg & ~err_mask) || |(warn_reg & ~warn_mask); // RL6
   assign low_supply_flag = (supply_pin_low_detect && !err_mask[`ASA_ERR_PIN_LOW])
      || (regulator_low_detect && !err_mask[`ASA_ERR_REG_LOW]); // RL7
   assign angle_word = {1'b0, any_fault_flag, low_supply_flag, // RL5
      ~^{any_fault_flag, low_supply_flag, sense.angle}, sense.angle}; // RL8 RL9
   assign status_word = {`ASA_TAG_STATUS, 2'b00, sense.die_number, // RL10
      sense.rotation_direction, 1'b0, action_done_reg, boot_done_reg, // RL11
      sense.logic_selftest_running, sense.frontend_selftest_running, // RL14
      sense.boot_in_progress, angle_valid}; // RL15 RL16

   always_comb begin
      case (acc.addr)
         `ASA_OFS_ANGLE: rd_word = angle_word;
         `ASA_OFS_STATUS: rd_word = status_word;
         `ASA_OFS_ERR: rd_word = {`ASA_TAG_ERR, err_reg}; // RL10
         `ASA_OFS_WARN: rd_word = {`ASA_TAG_WARN, warn_reg};
         `ASA_OFS_CTRL: rd_word = {special_reg, 12'h000}; // RL1 RL2 RL3
         default: rd_word = 16'h0000;
      endcase
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         rdata_reg <= 16'h0000;
      end else if (acc_go && !acc.wr) begin
         rdata_reg <= rd_word;
      end
   end

   // ****************************************************************
   // checks
   // ****************************************************************
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (srst);

   property p_clear_bits_zero;
      rd_ctrl |=> (rdata_reg[`ASA_CTRL_CLR_WARN] == 1'b0) && (rdata_reg[`ASA_CTRL_CLE] == 1'b0);
   endproperty
   a_clear_bits_zero: assert property (p_clear_bits_zero) // RL1
      else $error("clear bits read back nonzero");

   property p_err_clear_keeps;
      cle_hit |=> ((err_reg & ~$past(err_seen_reg)) & $past(err_reg))
         == ($past(err_unread));
   endproperty
   a_err_clear_keeps: assert property (p_err_clear_keeps) // RL2
      else $error("error clear dropped an unread bit");

   property p_initiate_zero;
      rd_ctrl |=> rdata_reg[7:0] == 8'h00;
   endproperty
   a_initiate_zero: assert property (p_initiate_zero) // RL3
      else $error("initiate field read back nonzero");

   property p_bad_key;
      wr_ctrl && (key != `ASA_KEY_SELFTEST) |=>
         !launch_reg.frontend_selftest && !launch_reg.logic_selftest;
   endproperty
   a_bad_key: assert property (p_bad_key) // RL4
      else $error("self-test launched without its key");

   property p_angle_field;
      rd_angle |=> (rdata_reg[11:0] == $past(sense.angle)) && !rdata_reg[15];
   endproperty
   a_angle_field: assert property (p_angle_field) // RL5
      else $error("angle word layout wrong");

   property p_fault_flag;
      rd_angle && (|(err_reg & ~err_mask)) |=> rdata_reg[14];
   endproperty
   a_fault_flag: assert property (p_fault_flag) // RL6
      else $error("fault flag missing on unmasked error");

   property p_odd_parity;
      rd_angle |=> ^rdata_reg;
   endproperty
   a_odd_parity: assert property (p_odd_parity) // RL8
      else $error("angle word parity is even");

   property p_tags;
      (rd_status |=> rdata_reg[15:12] == 4'h8) and (rd_err |=> rdata_reg[15:12] == 4'ha);
   endproperty
   a_tags: assert property (p_tags) // RL10
      else $error("register tag bits wrong");

   sequence s_launch;
      any_go ##1 !sense.action_done_evt;
   endsequence
   property p_done_drops;
      s_launch |-> !action_done_reg;
   endproperty
   a_done_drops: assert property (p_done_drops) // RL12
      else $error("action done not cleared by launch");

   property p_angle_valid;
      rd_status && sense.loop_locked && sense.startup_done |=> rdata_reg[0];
   endproperty
   a_angle_valid: assert property (p_angle_valid) // RL16
      else $error("angle valid missing while locked");

   property p_err_sticky;
      !cle_hit |=> (err_reg & $past(err_reg)) == $past(err_reg);
   endproperty
   a_err_sticky: assert property (p_err_sticky) // RL17
      else $error("error bit fell without a clear");

   property p_war_set;
      (|(warn_reg & ~warn_mask)) && !err_mask[`ASA_ERR_WARN_SUM] |=> err_reg[`ASA_ERR_WARN_SUM];
   endproperty
   a_war_set: assert property (p_war_set) // RL18
      else $error("warning summary not latched");
endmodule : asa_status_ctrl_regs

// ===== test/asa_host_model.sv
// host controller model: issues single register accesses over the link
`timescale 1ns/1ns
module asa_host_model (
   input wire logic link_clock,
   input wire logic link_busy,
   input wire logic link_done,
   input wire logic [15:0] link_rdata,
   output logic link_req,
   output asa_pkg::asa_req_type link_req_data
);
   // ********
   // link access
   // ********
   initial begin
      link_req = 1'b0;
      link_req_data = '0;
   end

   // request and its data held until the edge that samples link_done
   task automatic xfer(input logic wr, input logic [7:0] addr, input logic [15:0] wdata,
      output logic [15:0] rdata, output logic ok);
      int n;
      ok = 1'b0;
      rdata = 16'h0000;
      @(posedge link_clock);
      #2;
      link_req_data = '{wr: wr, addr: addr, wdata: wdata};
      link_req = 1'b1;
      for (n = 0; n < 40 && ok !== 1'b1; n++) begin
         @(posedge link_clock);
         if (link_done === 1'b1) begin
            ok = 1'b1;
            rdata = link_rdata;
         end
      end
      #2;
      link_req = 1'b0;
      // released data shows the inverse so a stale copy is never mistaken for a request
      link_req_data = ~link_req_data;
   endtask : xfer
endmodule : asa_host_model

// ===== test/asa_status_ctrl_regs_tb.sv
// self-checking bench for the angle sensor status and control registers
`timescale 1ns/1ns
module asa_status_ctrl_regs_tb;
   typedef struct packed {
      asa_pkg::asa_sense_type s;
      logic [7:0] a;
      logic [15:0] e;
   } asa_row_type;
   logic clock = 1'b0;
   logic link_clock = 1'b0;
   logic srst = 1'b1;
   logic link_req, link_busy, link_done;
   asa_pkg::asa_req_type link_req_data;
   logic [15:0] link_rdata;
   asa_pkg::asa_sense_type sense = '0;
   logic [10:0] fault_evt = '0;
   logic supply_pin_low_detect = 1'b0;
   logic regulator_low_detect = 1'b0;
   logic [11:0] warn_evt = '0;
   logic [11:0] err_mask = 12'h001;
   logic [11:0] warn_mask = '0;
   asa_pkg::asa_launch_type launch_reg;
   logic [3:0] seen_launch = '0;
   int fails = 0;
   int cmp_count = 0;
   int i;
   // rows: sense, offset, expected word; reset bit masked so the fault flag reads zero
   asa_row_type rows [13] = '{'{22'h0, 8'h22, 16'h8000}, '{22'h300, 8'h22, 16'h8001},
      '{22'h200, 8'h22, 16'h8000}, '{22'h0f3, 8'h22, 16'h838e}, '{22'h0, 8'h20, 16'h1000},
      '{22'h3ffc00, 8'h20, 16'h1fff}, '{22'h400, 8'h20, 16'h0001},
      '{22'h169400, 8'h20, 16'h15a5}, '{22'h200000, 8'h20, 16'h0800},
      '{22'h0, 8'h24, 16'ha001}, '{22'h0, 8'h26, 16'hb000}, '{22'h0, 8'h1e, 16'h0000},
      '{22'h0, 8'h28, 16'h0000}};
   // selection, key, expected launch
   logic [15:0] ltab [9] = '{16'h9b98, 16'hab94, 16'hbb9c, 16'h4462, 16'h75a1, 16'h9460,
      16'h4b90, 16'h7a50, 16'ha5a0};

   always #25 clock = ~clock;
   initial begin
      #13;
      forever #40 link_clock = ~link_clock;
   end
   always @(posedge clock) seen_launch = seen_launch | launch_reg;

   asa_status_ctrl_regs u_dut (.clock, .srst, .link_clock, .link_req, .link_req_data,
      .link_busy, .link_done, .link_rdata, .sense, .fault_evt, .supply_pin_low_detect,
      .regulator_low_detect, .warn_evt, .err_mask, .warn_mask, .launch_reg);
   asa_host_model u_host (.link_clock, .link_busy, .link_done, .link_rdata, .link_req,
      .link_req_data);

   // ********
   // helpers
   // ********
   task automatic finish_test();
      $display("counts: %0d compares, %0d mismatches", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : finish_test
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fails++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic acc(input logic w, input logic [7:0] a, input logic [15:0] d,
      output logic [15:0] q);
      logic ok;
      u_host.xfer(w, a, d, q, ok);
      if (ok !== 1'b1) begin
         fails++;
         $display("wrong value at %0t: seen %h expected %h", $time, 1'b0, 1'b1);
         finish_test();
      end
      // realign to the core clock so later core-side stimulus never lands on its edge
      tick();
   endtask : acc
   task automatic rd(input logic [7:0] a, input logic [15:0] e);
      logic [15:0] q;
      acc(1'b0, a, 16'h0000, q);
      check(q, e);
   endtask : rd
   task automatic wr(input logic [15:0] d);
      logic [15:0] q;
      acc(1'b1, 8'h1e, d, q);
   endtask : wr
   task automatic tick();
      @(posedge clock);
      #2;
   endtask : tick
   task automatic reset_dut();
      srst = 1'b1;
      repeat (16) tick();
      srst = 1'b0;
      repeat (5) @(posedge link_clock);
   endtask : reset_dut

   // ********
   // main sequence
   // ********
   initial begin
      reset_dut();
      check({14'h0, link_busy, link_done}, 16'h0000);
      check({12'h000, launch_reg}, 16'h0000);
      for (i = 0; i < 13; i++) begin
         tick();
         sense = rows[i].s;
         rd(rows[i].a, rows[i].e);
      end
      sense = '0;
      $display("test table done");
      // latched errors clear only after being read
      rd(8'h24, 16'ha001);
      wr(16'h0100);
      rd(8'h24, 16'ha000);
      for (i = 6; i < 11; i++) begin
         tick();
         fault_evt[i] = 1'b1;
         tick();
         fault_evt = '0;
         repeat (4) tick();
         rd(8'h24, 16'ha000 | (16'h0001 << i));
         wr(16'h0100);
         rd(8'h24, 16'ha000);
      end
      fault_evt[8] = 1'b1;
      tick();
      fault_evt = '0;
      rd(8'h24, 16'ha100);
      fault_evt[7] = 1'b1;
      tick();
      fault_evt = '0;
      wr(16'h0100);
      rd(8'h24, 16'ha080);
      wr(16'h0100);
      rd(8'h24, 16'ha000);
      rd(8'h1e, 16'h0000);
      $display("test errors done");
      err_mask = '0;
      rd(8'h20, 16'h1000);
      warn_evt[4] = 1'b1;
      tick();
      warn_evt = '0;
      rd(8'h26, 16'hb010);
      rd(8'h24, 16'ha800);
      rd(8'h20, 16'h4000);
      warn_mask = 12'h010;
      err_mask = 12'h800;
      rd(8'h20, 16'h1000);
      wr(16'h0200);
      rd(8'h26, 16'hb000);
      rd(8'h1e, 16'h0000);
      warn_evt[9] = 1'b1;
      tick();
      warn_evt = '0;
      rd(8'h26, 16'hb000);
      $display("test warnings done");
      supply_pin_low_detect = 1'b1;
      rd(8'h20, 16'h7000);
      err_mask = 12'h808;
      rd(8'h20, 16'h1000);
      supply_pin_low_detect = 1'b0;
      regulator_low_detect = 1'b1;
      rd(8'h20, 16'h7000);
      regulator_low_detect = 1'b0;
      $display("test supply done");
      sense.boot_done_evt = 1'b1;
      tick();
      sense.boot_done_evt = 1'b0;
      rd(8'h22, 16'h8010);
      for (i = 0; i < 9; i++) begin
         wr({ltab[i][15:12], 12'h000});
         seen_launch = '0;
         wr({ltab[i][15:12], 4'h0, ltab[i][11:4]});
         repeat (3) tick();
         check({12'h000, seen_launch}, {12'h000, ltab[i][3:0]});
         rd(8'h1e, {ltab[i][15:12], 12'h000});
      end
      sense.action_done_evt = 1'b1;
      tick();
      sense.action_done_evt = 1'b0;
      rd(8'h22, 16'h8030);
      rd(8'h1e, 16'h0000);
      wr(16'h9000);
      wr(16'h90b9);
      rd(8'h22, 16'h8010);
      sense.action_done_evt = 1'b1;
      tick();
      sense.action_done_evt = 1'b0;
      wr(16'h0400);
      rd(8'h22, 16'h8000);
      $display("test launch done");
      fault_evt[10] = 1'b1;
      tick();
      fault_evt = '0;
      reset_dut();
      rd(8'h24, 16'ha001);
      $display("test second reset done");
      finish_test();
   end
endmodule : asa_status_ctrl_regs_tb
